// >>> adcsd_pkg.sv
// Constants, types and state layout of the serial command decoder.
// Assumes a 50 MHz system clock and an SPI-00 style host on the link.
// Behaviour
// R1: Command bits sampled only on host serial clock.
// R2: Halfword commands force address bit 0 low.
// R3: Opcode 11000 clears pair bits where data is 1.
// R4: Opcode 11011 sets pair bits where data is 1.
// R5: Opcode 11001, zero data: return halfword next frame.
// R6: Opcode 01001, zero data: return one byte next.
// R7: Write sub-field 00 stores both data bytes.
// R8: Write sub-field 01 stores upper byte only.
// R9: Write sub-field 10 stores lower byte only.
// R10: Unknown or all-zero words do nothing.
// R11: Host puts zero above 8-bit register address.
// R12: 32-bit command executes at select rising edge.
// R13: Output shift register shifts out each frame.
// R14: Fixed pattern select 1xx wins output word.
// R15: Byte read: value in top bits, rest zero.
// R16: Halfword read: value in top bits, rest zero.
// R17: Otherwise output starts with latest conversion result.
// R18: Enabled flag fields appended in fixed order.
// R19: Unused output word bits are zero.
// R20: Output launch clock selectable: serial or internal.
// R21: Select fall clears counter and command register.
// R22: Each captured bit enters input register LSB.
// R23: Under 32 clocks is no-op; over keeps last 32.
// R24: All enabled: fields at 31:16,15:12,11:8,7:6,5:4,3:2.
// R25: Opcode 31:27, sub 26:25, address 24:16, data 15:0.
package adcsd_pkg;

  // Register byte store depth
  localparam int REG_BYTES = 16;

  // Bus register offsets
  localparam logic [11:0] OFF_CFG = 12'h000;
  localparam logic [11:0] OFF_FIXED = 12'h004;
  localparam logic [11:0] OFF_CONV = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00C;

  // Reset values
  localparam logic [8:0] CFG_RST = 9'h000;
  localparam logic [31:0] FIXED_RST = 32'h0000_0000;
  localparam logic [27:0] CONV_RST = 28'h000_0000;

  // Command word fields and opcodes
  localparam int OP_MSB = 31;
  localparam int SUB_MSB = 26;
  localparam int ADDR_MSB = 24;
  localparam logic [4:0] OP_CLEAR = 5'h18;
  localparam logic [4:0] OP_READ_HALF = 5'h19;
  localparam logic [4:0] OP_READ_BYTE = 5'h09;
  localparam logic [4:0] OP_WRITE = 5'h1A;
  localparam logic [4:0] OP_SET = 5'h1B;
  localparam logic [1:0] SUB_BOTH = 2'h0;
  localparam logic [1:0] SUB_UPPER = 2'h1;
  localparam logic [1:0] SUB_LOWER = 2'h2;

  // Frame counting and internal launch clock
  localparam logic [5:0] FRAME_BITS = 6'h20;
  localparam logic [5:0] CNT_SAT = 6'h21;
  localparam logic [3:0] INT_DIV_LAST = 4'h3;

  typedef enum logic [1:0] {
    LS_IDLE = 2'b01,
    LS_FRAME = 2'b10
  } adcsd_link_e;

  typedef enum logic [2:0] {
    RK_NONE = 3'b001,
    RK_BYTE = 3'b010,
    RK_HALF = 3'b100
  } adcsd_read_e;

  // output_word_config layout, bit 8 down to bit 0
  typedef struct packed {
    logic int_clk;
    logic parity_append_en;
    logic append_input_alarm_en;
    logic append_supply_alarm_en;
    logic append_range_en;
    logic append_chip_tag_en;
    logic [2:0] fixed_pattern_select;
  } adcsd_cfg_s;

  // Conversion register layout, bit 27 down to bit 0
  typedef struct packed {
    logic [1:0] input_alarm;
    logic [1:0] supply_alarm;
    logic [3:0] range_code;
    logic [3:0] chip_tag;
    logic [15:0] result;
  } adcsd_conv_s;

  typedef struct packed {
    logic [2:0] cs_p;
    logic [2:0] sclk_p;
    logic [1:0] sdi_p;
    adcsd_link_e ls;
    logic [5:0] cnt;
    logic [31:0] isr;
    logic [31:0] osr;
    logic sdo;
    logic sdo_oe;
    logic [3:0] div;
    adcsd_read_e rk;
    logic [15:0] rd_data;
    adcsd_cfg_s cfg;
    logic [31:0] fixed;
    adcsd_conv_s conv;
    logic [REG_BYTES-1:0][7:0] regs;
    logic [4:0] last_op;
    logic last_exec;
    logic [11:0] a_addr;
    logic a_wr;
    logic a_rd;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } adcsd_state_s;

endpackage

// >>> adcsd_decoder.sv
// Serial command decoder with register byte store and AHB-Lite slave.
// Assumes host link pins are asynchronous to hclk; SPI-00 timing.
`timescale 1ns/1ns
module adcsd_decoder (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Host link
  input wire logic convert_select,
  input wire logic serial_clk,
  input wire logic serial_in,
  output logic serial_out_lanes,
  output logic serial_out_lanes_oe
);

  adcsd_pkg::adcsd_state_s st;
  adcsd_pkg::adcsd_state_s nx;

  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic launch;
  logic exec_now;
  logic [4:0] op;
  logic [1:0] sub;
  logic [8:0] a9;
  logic [8:0] ea;
  logic [15:0] dat;
  logic a_ok;
  logic e_ok;
  logic [3:0] ai;
  logic [3:0] ei;
  logic [3:0] eip;
  logic [31:0] out_word;

  // Output word with appended flag fields
  function automatic logic [31:0] pack_word(
    input adcsd_pkg::adcsd_cfg_s c,
    input adcsd_pkg::adcsd_conv_s v
  );
    logic [31:0] w;
    int pos;
    logic fx;
    w = {v.result, 16'h0000}; // [R17] [R19]
    pos = 16;
    fx = 1'b0;
    if (c.append_chip_tag_en) begin // [R18] [R24]
      pos = pos - 4;
      w[pos +: 4] = v.chip_tag;
      fx = fx ^ (^v.chip_tag);
    end
    if (c.append_range_en) begin // [R18]
      pos = pos - 4;
      w[pos +: 4] = v.range_code;
      fx = fx ^ (^v.range_code);
    end
    if (c.append_supply_alarm_en) begin // [R18]
      pos = pos - 2;
      w[pos +: 2] = v.supply_alarm;
      fx = fx ^ (^v.supply_alarm);
    end
    if (c.append_input_alarm_en) begin // [R18]
      pos = pos - 2;
      w[pos +: 2] = v.input_alarm;
      fx = fx ^ (^v.input_alarm);
    end
    if (c.parity_append_en) begin // [R18]
      pos = pos - 2;
      w[pos +: 2] = {^v.result, fx};
    end
    return w;
  endfunction

  // Bus register read mux
  function automatic logic [31:0] bus_read(
    input adcsd_pkg::adcsd_state_s s,
    input logic [11:0] a
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      adcsd_pkg::OFF_CFG: r = {23'h00_0000, s.cfg};
      adcsd_pkg::OFF_FIXED: r = s.fixed;
      adcsd_pkg::OFF_CONV: r = {4'h0, s.conv};
      adcsd_pkg::OFF_STATUS: r = {21'h00_0000, s.ls, s.rk,
                                  s.last_exec, s.last_op};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // Edge detectors read only the second and third stages
  assign cs_fall = st.cs_p[2] & ~st.cs_p[1];
  assign cs_rise = ~st.cs_p[2] & st.cs_p[1];
  assign sclk_rise = ~st.sclk_p[2] & st.sclk_p[1];
  assign sclk_fall = st.sclk_p[2] & ~st.sclk_p[1];
  // Launch source select
  assign launch = st.cfg.int_clk ? (st.div == adcsd_pkg::INT_DIV_LAST)
                                 : sclk_fall; // [R20]

  // Command word fields
  assign op = st.isr[adcsd_pkg::OP_MSB -: 5]; // [R25]
  assign sub = st.isr[adcsd_pkg::SUB_MSB -: 2]; // [R25]
  assign a9 = st.isr[adcsd_pkg::ADDR_MSB -: 9]; // [R25]
  assign dat = st.isr[15:0]; // [R25]
  assign ea = {a9[8:1], 1'b0}; // [R2]
  assign a_ok = a9 < 9'(adcsd_pkg::REG_BYTES);
  assign e_ok = ea < 9'(adcsd_pkg::REG_BYTES);
  assign ai = a9[3:0];
  assign ei = ea[3:0];
  assign eip = {ea[3:1], 1'b1};
  assign exec_now = (st.ls == adcsd_pkg::LS_FRAME) && cs_rise &&
                    (st.cnt >= adcsd_pkg::FRAME_BITS); // [R12] [R23]

  // Next frame's output word
  always_comb begin
    if (st.cfg.fixed_pattern_select[2]) begin
      out_word = st.fixed; // [R14]
    end else if (st.rk == adcsd_pkg::RK_BYTE) begin
      out_word = {st.rd_data[7:0], 24'h00_0000}; // [R15]
    end else if (st.rk == adcsd_pkg::RK_HALF) begin
      out_word = {st.rd_data, 16'h0000}; // [R16]
    end else begin
      out_word = pack_word(st.cfg, st.conv); // [R17]
    end
  end

  always_comb begin
    nx = st;
    // Pin synchronisers
    nx.cs_p = {st.cs_p[1:0], convert_select};
    nx.sclk_p = {st.sclk_p[1:0], serial_clk};
    nx.sdi_p = {st.sdi_p[0], serial_in};
    case (st.ls)
      adcsd_pkg::LS_IDLE: begin
        if (cs_fall) begin
          nx.ls = adcsd_pkg::LS_FRAME;
          nx.cnt = 6'h00; // [R21]
          nx.isr = 32'h0000_0000; // [R21]
          nx.osr = out_word; // [R13]
          nx.sdo = out_word[31];
          nx.sdo_oe = 1'b1;
          nx.div = 4'h0;
        end
      end
      adcsd_pkg::LS_FRAME: begin
        if (cs_rise) begin
          nx.ls = adcsd_pkg::LS_IDLE;
          nx.sdo_oe = 1'b0;
          nx.sdo = 1'b0;
          nx.rk = adcsd_pkg::RK_NONE;
          nx.last_op = op;
          nx.last_exec = exec_now;
          if (exec_now) begin // [R12]
            case (op)
              adcsd_pkg::OP_CLEAR: begin
                if (e_ok) begin // [R3]
                  nx.regs[eip] = st.regs[eip] & ~dat[15:8];
                  nx.regs[ei] = st.regs[ei] & ~dat[7:0];
                end
              end
              adcsd_pkg::OP_SET: begin
                if (e_ok) begin // [R4]
                  nx.regs[eip] = st.regs[eip] | dat[15:8];
                  nx.regs[ei] = st.regs[ei] | dat[7:0];
                end
              end
              adcsd_pkg::OP_WRITE: begin
                if (e_ok && sub == adcsd_pkg::SUB_BOTH) begin // [R7]
                  nx.regs[eip] = dat[15:8];
                  nx.regs[ei] = dat[7:0];
                end else if (e_ok && sub == adcsd_pkg::SUB_UPPER) begin
                  nx.regs[eip] = dat[15:8]; // [R8]
                end else if (e_ok && sub == adcsd_pkg::SUB_LOWER) begin
                  nx.regs[ei] = dat[7:0]; // [R9]
                end
              end
              adcsd_pkg::OP_READ_HALF: begin
                if (dat == 16'h0000) begin // [R5]
                  nx.rk = adcsd_pkg::RK_HALF;
                  nx.rd_data = e_ok ? {st.regs[eip], st.regs[ei]}
                                    : 16'h0000;
                end
              end
              adcsd_pkg::OP_READ_BYTE: begin
                if (dat == 16'h0000) begin // [R6]
                  nx.rk = adcsd_pkg::RK_BYTE;
                  nx.rd_data = {8'h00, a_ok ? st.regs[ai] : 8'h00};
                end
              end
              default: begin
                nx.rk = adcsd_pkg::RK_NONE; // [R10]
              end
            endcase
          end
        end else begin
          if (sclk_rise) begin // [R1] [R22]
            nx.isr = {st.isr[30:0], st.sdi_p[1]};
            if (st.cnt != adcsd_pkg::CNT_SAT) begin
              nx.cnt = st.cnt + 6'h01;
            end
          end
          nx.div = launch ? 4'h0 : st.div + 4'h1;
          if (launch) begin // [R13] [R20]
            nx.osr = {st.osr[30:0], 1'b0};
            nx.sdo = st.osr[30];
          end
        end
      end
      default: begin
        nx.ls = adcsd_pkg::LS_IDLE;
        nx.sdo_oe = 1'b0;
      end
    endcase
    // Bus data phase
    if (st.a_wr) begin
      case (st.a_addr)
        adcsd_pkg::OFF_CFG: nx.cfg = hwdata[8:0];
        adcsd_pkg::OFF_FIXED: nx.fixed = hwdata;
        adcsd_pkg::OFF_CONV: nx.conv = hwdata[27:0];
        default: nx.hresp = 1'b0;
      endcase
    end
    nx.a_wr = 1'b0;
    if (st.a_rd) begin
      nx.hrdata = bus_read(st, st.a_addr);
      nx.hreadyout = 1'b1;
      nx.a_rd = 1'b0;
    end
    // Bus address phase
    if (hsel && htrans[1] && hready) begin
      nx.a_addr = {haddr[11:2], 2'b00};
      nx.a_wr = hwrite;
      nx.a_rd = ~hwrite;
      nx.hreadyout = hwrite;
    end
    nx.hresp = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.cs_p <= 3'h7;
      st.ls <= adcsd_pkg::LS_IDLE;
      st.rk <= adcsd_pkg::RK_NONE;
      st.cfg <= adcsd_pkg::CFG_RST;
      st.fixed <= adcsd_pkg::FIXED_RST;
      st.conv <= adcsd_pkg::CONV_RST;
      st.hreadyout <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  assign hrdata = st.hrdata;
  assign hreadyout = st.hreadyout;
  assign hresp = st.hresp;
  assign serial_out_lanes = st.sdo;
  assign serial_out_lanes_oe = st.sdo_oe;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_frame_start: assert property ( // [R21]
    st.ls == adcsd_pkg::LS_IDLE && cs_fall |=>
      st.cnt == 6'h00 && st.isr == 32'h0000_0000 && st.sdo_oe)
    else $error("frame start did not clear counter and command");

  a_capture_lsb: assert property ( // [R22]
    st.ls == adcsd_pkg::LS_FRAME && sclk_rise && !cs_rise |=>
      st.isr[0] == $past(st.sdi_p[1]) &&
      st.isr[31:1] == $past(st.isr[30:0]))
    else $error("serial bit not shifted into lsb");

  a_short_frame_nop: assert property ( // [R23]
    st.ls == adcsd_pkg::LS_FRAME && cs_rise &&
    st.cnt < adcsd_pkg::FRAME_BITS |=> st.regs == $past(st.regs))
    else $error("short frame changed registers");

  a_clear_bits: assert property ( // [R3]
    exec_now && op == adcsd_pkg::OP_CLEAR && e_ok |=>
      ({st.regs[$past(eip)], st.regs[$past(ei)]} & $past(dat)) == 16'h0000)
    else $error("bit clear left a bit set");

  a_set_bits: assert property ( // [R4]
    exec_now && op == adcsd_pkg::OP_SET && e_ok |=>
      ({st.regs[$past(eip)], st.regs[$past(ei)]} & $past(dat)) ==
      $past(dat))
    else $error("bit set left a bit clear");

  a_halfword_even: assert property ( // [R7]
    exec_now && op == adcsd_pkg::OP_WRITE && sub == adcsd_pkg::SUB_BOTH &&
    e_ok |=> {st.regs[$past(eip)], st.regs[$past(ei)]} == $past(dat))
    else $error("halfword write not stored at even pair");

  a_upper_only: assert property ( // [R8]
    exec_now && op == adcsd_pkg::OP_WRITE && sub == adcsd_pkg::SUB_UPPER &&
    e_ok |=> st.regs[$past(eip)] == $past(dat[15:8]) &&
      st.regs[$past(ei)] == $past(st.regs[ei]))
    else $error("upper byte write disturbed lower byte");

  a_fixed_first: assert property ( // [R14]
    st.ls == adcsd_pkg::LS_IDLE && cs_fall &&
    st.cfg.fixed_pattern_select[2] |=> st.osr == $past(st.fixed))
    else $error("fixed pattern not loaded");

  a_byte_zero_fill: assert property ( // [R15]
    st.ls == adcsd_pkg::LS_IDLE && cs_fall &&
    !st.cfg.fixed_pattern_select[2] && st.rk == adcsd_pkg::RK_BYTE |=>
      st.osr == {$past(st.rd_data[7:0]), 24'h00_0000})
    else $error("byte read word malformed");

  a_shift_msb: assert property ( // [R13]
    st.ls == adcsd_pkg::LS_FRAME && !cs_rise && launch |=>
      st.sdo == $past(st.osr[30]) && st.sdo_oe)
    else $error("output bit not launched from shift register");

  a_lower_only: assert property ( // [R9]
    exec_now && op == adcsd_pkg::OP_WRITE && sub == adcsd_pkg::SUB_LOWER &&
    e_ok |=> st.regs[$past(ei)] == $past(dat[7:0]) &&
      st.regs[$past(eip)] == $past(st.regs[eip]))
    else $error("lower byte write disturbed upper byte");

  a_half_capture: assert property ( // [R5]
    exec_now && op == adcsd_pkg::OP_READ_HALF && dat == 16'h0000 &&
    e_ok |=> st.rk == adcsd_pkg::RK_HALF &&
      st.rd_data == {$past(st.regs[eip]), $past(st.regs[ei])})
    else $error("halfword read not captured");

  a_byte_capture: assert property ( // [R6]
    exec_now && op == adcsd_pkg::OP_READ_BYTE && dat == 16'h0000 &&
    a_ok |=> st.rk == adcsd_pkg::RK_BYTE &&
      st.rd_data == {8'h00, $past(st.regs[ai])})
    else $error("byte read not captured");

  a_half_zero_fill: assert property ( // [R16]
    st.ls == adcsd_pkg::LS_IDLE && cs_fall &&
    !st.cfg.fixed_pattern_select[2] && st.rk == adcsd_pkg::RK_HALF |=>
      st.osr == {$past(st.rd_data), 16'h0000})
    else $error("halfword read word malformed");

  a_nop_keeps: assert property ( // [R10]
    exec_now && op != adcsd_pkg::OP_CLEAR && op != adcsd_pkg::OP_SET &&
    op != adcsd_pkg::OP_WRITE |=> st.regs == $past(st.regs))
    else $error("non-writing command changed registers");

  a_exec_on_rise: assert property ( // [R12]
    !exec_now |=> st.regs == $past(st.regs))
    else $error("registers changed outside command execution");

  a_conv_lead: assert property ( // [R17]
    st.ls == adcsd_pkg::LS_IDLE && cs_fall &&
    !st.cfg.fixed_pattern_select[2] && st.rk == adcsd_pkg::RK_NONE |=>
      st.osr[31:16] == $past(st.conv.result))
    else $error("output word does not lead with result");

  a_read_wait: assert property (
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase did not take one wait state");

  c_write_exec: cover property (exec_now && op == adcsd_pkg::OP_WRITE);
  c_half_read: cover property (cs_fall && st.rk == adcsd_pkg::RK_HALF);
  c_short_frame: cover property (
    st.ls == adcsd_pkg::LS_FRAME && cs_rise &&
    st.cnt < adcsd_pkg::FRAME_BITS);
  c_int_launch: cover property (st.cfg.int_clk && launch);

endmodule

// >>> adcsd_host.sv
// Host controller model: drives select, serial clock and command bits.
// Assumes a device that captures on rising and launches on falling clock.
`timescale 1ns/1ns
module adcsd_host (
  // Link pins
  output logic convert_select,
  output logic serial_clk,
  output logic serial_in,
  input wire logic serial_out_lanes,
  input wire logic serial_out_lanes_oe
);
  initial begin
    convert_select = 1'b1;
    serial_clk = 1'b0;
    serial_in = 1'b0;
  end

  // One frame of n clocks; the last 32 bits sent form the command
  task automatic frame(input logic [31:0] cmd, input int n,
                       output logic [31:0] rx);
    rx = 32'h0000_0000;
    #7;
    convert_select = 1'b0;
    for (int k = n - 1; k >= 0; k--) begin
      serial_in = (k < 32) ? cmd[k] : k[0];
      #80;
      serial_clk = 1'b1;
      if (k >= n - 32) begin
        rx = {rx[30:0], serial_out_lanes};
      end
      if (serial_out_lanes_oe !== 1'b1) begin
        rx = 32'hxxxx_xxxx;
      end
      #80;
      serial_clk = 1'b0;
    end
    convert_select = 1'b1;
    serial_in = ~serial_in;
    #200;
  endtask
endmodule

// >>> tb_adc_serial_command_decoder.sv
// Self-checking bench for the serial command decoder.
// Assumes one bus slave and the host model on the link side.
`timescale 1ns/1ns
module tb_adc_serial_command_decoder;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic convert_select;
  logic serial_clk;
  logic serial_in;
  logic serial_out_lanes;
  logic serial_out_lanes_oe;
  logic [31:0] rx;
  int miscompares;
  int checks_done;

  adcsd_decoder dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .convert_select(convert_select), .serial_clk(serial_clk),
    .serial_in(serial_in), .serial_out_lanes(serial_out_lanes),
    .serial_out_lanes_oe(serial_out_lanes_oe));

  adcsd_host host_u (.convert_select(convert_select),
    .serial_clk(serial_clk), .serial_in(serial_in),
    .serial_out_lanes(serial_out_lanes),
    .serial_out_lanes_oe(serial_out_lanes_oe));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("BAD %s exp %h got %h", what, exp, got);
      miscompares++;
    end
  endtask

  task automatic wait_ready();
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1)
        break;
    end
    if (i == 20) begin
      $display("BAD bus wait exp ready got stall");
      miscompares++;
      print_verdict();
    end
  endtask

  // One single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0_0000, a};
    hwrite <= wr;
    hsize <= 3'b010;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  function automatic logic [31:0] cmd(input logic [4:0] op,
      input logic [1:0] sub, input logic [7:0] a, input logic [15:0] d);
    return {op, sub, 1'b0, a, d};
  endfunction

  task automatic fr(input logic [31:0] c, input int n = 32);
    host_u.frame(c, n, rx);
  endtask

  task automatic t_bus();
    logic [31:0] d;
    chk("oe idle", 32'h0000_0000, {31'h0, serial_out_lanes_oe});
    bus(1'b1, adcsd_pkg::OFF_CONV, 32'h036C_8003, d);
    bus(1'b0, adcsd_pkg::OFF_CONV, 32'h0000_0000, d);
    chk("conv reg", 32'h036C_8003, d);
    bus(1'b1, 12'h010, 32'hFFFF_FFFF, d);
    bus(1'b0, 12'h010, 32'h0000_0000, d);
    chk("unmapped", 32'h0000_0000, d);
    chk("hresp okay", 32'h0000_0000, {31'h0, hresp});
  endtask

  task automatic t_out();
    logic [31:0] d;
    bus(1'b1, adcsd_pkg::OFF_FIXED, 32'h5A5A_C3C3, d);
    fr(32'h0000_0000);
    chk("plain word", {16'h8003, 16'h0000}, rx);
    bus(1'b1, adcsd_pkg::OFF_CFG, 32'h0000_00F8, d);
    fr(32'h0000_0000);
    chk("all flags", {16'h8003, 4'hC, 4'h6, 2'h3, 2'h0, 2'h2, 2'h0},
        rx);
    bus(1'b1, adcsd_pkg::OFF_CFG, 32'h0000_00B0, d);
    fr(32'h0000_0000);
    chk("some flags", {16'h8003, 4'h6, 2'h3, 2'h2, 8'h00}, rx);
    bus(1'b1, adcsd_pkg::OFF_CFG, 32'h0000_0004, d);
    fr(cmd(adcsd_pkg::OP_WRITE, 2'h0, 8'h0A, 16'h1111));
    fr(cmd(adcsd_pkg::OP_READ_HALF, 2'h0, 8'h0A, 16'h0000));
    fr(32'h0000_0000);
    chk("fixed wins", 32'h5A5A_C3C3, rx);
    bus(1'b1, adcsd_pkg::OFF_CFG, 32'h0000_0000, d);
  endtask

  task automatic t_intclk();
    logic [31:0] d;
    bus(1'b1, adcsd_pkg::OFF_CFG, 32'h0000_0100, d);
    fr(32'h0000_0000);
    // Launch every 4 hclk, so the host sees every other bit
    chk("internal launch", 32'h8100_0000, rx);
    bus(1'b1, adcsd_pkg::OFF_CFG, 32'h0000_0000, d);
  endtask

  task automatic t_half();
    fr(cmd(adcsd_pkg::OP_WRITE, 2'h0, 8'h05, 16'hBEEF));
    fr(cmd(adcsd_pkg::OP_READ_HALF, 2'h0, 8'h05, 16'h0000));
    fr(32'h0000_0000);
    chk("half read", {16'hBEEF, 16'h0000}, rx);
  endtask

  task automatic t_bytes();
    fr(cmd(adcsd_pkg::OP_WRITE, 2'h1, 8'h06, 16'hAB12));
    fr(cmd(adcsd_pkg::OP_WRITE, 2'h2, 8'h06, 16'h9934));
    fr(cmd(adcsd_pkg::OP_READ_BYTE, 2'h0, 8'h07, 16'h0000));
    fr(cmd(adcsd_pkg::OP_READ_BYTE, 2'h0, 8'h06, 16'h0000));
    chk("byte hi", {8'hAB, 24'h00_0000}, rx);
    fr(cmd(adcsd_pkg::OP_READ_HALF, 2'h0, 8'h06, 16'h0000));
    chk("byte lo", {8'h34, 24'h00_0000}, rx);
    fr(32'h0000_0000);
    chk("pair six", {16'hAB34, 16'h0000}, rx);
  endtask

  task automatic t_setclr();
    logic [31:0] d;
    fr(cmd(adcsd_pkg::OP_SET, 2'h0, 8'h04, 16'h0110));
    fr(cmd(adcsd_pkg::OP_CLEAR, 2'h0, 8'h05, 16'h8421));
    fr(cmd(adcsd_pkg::OP_READ_HALF, 2'h0, 8'h04, 16'h0000));
    fr(32'h0000_0000);
    chk("set clear", {(16'hBEEF | 16'h0110) & ~16'h8421, 16'h0000},
        rx);
    bus(1'b0, adcsd_pkg::OFF_STATUS, 32'h0000_0000, d);
    chk("status", 32'h0000_0260, d);
  endtask

  task automatic t_nop();
    fr(cmd(5'h1F, 2'h0, 8'h04, 16'hFFFF));
    fr(cmd(adcsd_pkg::OP_WRITE, 2'h3, 8'h04, 16'hFFFF));
    fr(cmd(adcsd_pkg::OP_SET, 2'h0, 8'h04, 16'hFFFF), 31);
    fr(cmd(adcsd_pkg::OP_READ_HALF, 2'h0, 8'h04, 16'h0001));
    fr(32'h0000_0000);
    chk("no read", {16'h8003, 16'h0000}, rx);
    fr(cmd(adcsd_pkg::OP_SET, 2'h0, 8'h04, 16'h0001), 40);
    fr(cmd(adcsd_pkg::OP_READ_HALF, 2'h0, 8'h04, 16'h0000));
    fr(32'h0000_0000);
    chk("long frame", {16'h3BDF, 16'h0000}, rx);
  endtask

  initial begin
    miscompares = 0;
    checks_done = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    t_bus();
    t_out();
    t_intclk();
    t_half();
    t_bytes();
    t_setclr();
    t_nop();
    print_verdict();
  end
endmodule
